// ### verilog/llc_softstart_protect_deadtime.sv
// Soft-start, overload and short protection with auto-restart, and dead-time programming.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "llc_ss_regs.svh"

// How it works
// - In steady run the soft-start node is clamped at 2.4 V and is the reference.
// - At power-up the startup source charges the soft-start node monotonically.
// - Saturated compensation releases the clamp and charges the node slowly upward.
// - Overload shutdown trips when the released node reaches 3.6 V.
// - Protections never latch; any trip drops the clamp and starts restart.
// - Restart charges the node to 4.7 V, then discharges it to 0.1 V.
// - Three more charge and discharge cycles follow the first before recovery.
// - Output short trips at once when feedback falls 1.2 V below reference.
// - After 5 V bias, node rises to 1.4 V, then discharges to 1 V.
// - Rise time 1 V to 3 V over 64 sets the rectifier dead time.
// - Fall time 3 V to 1 V over 32 sets the primary dead time.
// - After falling to 1 V the discharge source turns off; node charges to 5 V.
// - Intervals are counted in 40 MHz ticks, giving 25 ns steps.
// - Each dead time is limited between 75 ns and 375 ns.
// - In pulse-width mode the applied dead times are doubled.
// - Compensation below the mode threshold enters pulse-width mode and clamps it.
module llc_softstart_protect_deadtime #(
    parameter int TICK_W = 16
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire llc_ss_pkg::sense_s i_sense,
    output llc_ss_pkg::ss_drive_s o_ss_drive,
    output logic o_deadtime_discharge_source,
    output logic o_switch_en,
    output logic o_pwm_mode,
    output logic o_comp_clamp,
    output logic o_overload_shutdown,
    output logic o_output_short_trip,
    output logic [4:0] o_rect_deadtime,
    output logic [4:0] o_prim_deadtime,
    output logic o_deadtime_valid,
    input wire logic [2:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq
);
    import llc_ss_pkg::*;

    localparam logic [5:0] TICK_STEP = 6'(`DT_TICK_NS);
    localparam logic [5:0] CLK_STEP = 6'(`CLK_PERIOD_NS);
    localparam logic [3:0] MIN_STEPS = 4'(`DT_MIN_STEPS);
    localparam logic [3:0] MAX_STEPS = 4'(`DT_MAX_STEPS);
    localparam logic [1:0] RESTART_EXTRA = 2'(`RESTART_EXTRA);

    // Every comparator is asynchronous to the clock and passes two flip-flops.
    sense_s meta_reg;
    sense_s sense_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            sense_reg <= '0;
        end else begin
            meta_reg <= i_sense;
            sense_reg <= meta_reg;
        end
    end

    logic [31:0] ctrl_reg;
    logic [`EV_WIDTH-1:0] irq_status_reg;
    logic [`EV_WIDTH-1:0] irq_mask_reg;
    logic [`EV_WIDTH-1:0] events;
    logic bus_ack_reg;
    logic wr_take;
    logic run_en;
    assign run_en = ctrl_reg[`CTRL_RUN_BIT];

    // Dead-time programming sequence.
    dt_state_e dt_state_reg;
    logic [TICK_W-1:0] tick_reg;
    logic [5:0] frac_reg;
    logic [TICK_W-1:0] rise_interval_reg;
    logic [TICK_W-1:0] fall_interval_reg;
    logic dt_valid_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dt_state_reg <= DT_WAIT_BIAS;
        end else begin
            unique case (dt_state_reg)
                DT_WAIT_BIAS: begin
                    if (sense_reg.bias_5v_ok) dt_state_reg <= DT_PRE_RISE;
                end
                DT_PRE_RISE: begin
                    if (sense_reg.dtn_ge_1v4) dt_state_reg <= DT_PRE_FALL;
                end
                DT_PRE_FALL: begin
                    if (!sense_reg.dtn_ge_1v0) dt_state_reg <= DT_RISE;
                end
                DT_RISE: begin
                    if (sense_reg.dtn_ge_3v0) dt_state_reg <= DT_FALL;
                end
                DT_FALL: begin
                    if (!sense_reg.dtn_ge_1v0) dt_state_reg <= DT_DONE;
                end
                DT_DONE: begin
                    dt_state_reg <= DT_DONE;
                end
            endcase
        end
    end
    // Discharge source is on only while the node is being pulled down.
    assign o_deadtime_discharge_source = (dt_state_reg == DT_PRE_FALL) ||
                                         (dt_state_reg == DT_FALL);

    // The 40 MHz tick is rebuilt from the 25 MHz clock by a ns accumulator;
    // each clock adds 40 ns, so one or two ticks pass per clock.
    logic timing;
    logic [6:0] frac_sum;
    logic two_ticks;
    logic [TICK_W-1:0] tick_sum;
    assign timing = (dt_state_reg == DT_RISE) || (dt_state_reg == DT_FALL);
    assign frac_sum = {1'b0, frac_reg} + {1'b0, CLK_STEP};
    assign two_ticks = frac_sum >= 7'({TICK_STEP, 1'b0});
    assign tick_sum = tick_reg + (two_ticks ? TICK_W'(2) : TICK_W'(1));
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_reg <= '0;
            frac_reg <= '0;
        end else if (!timing) begin
            tick_reg <= '0;
            frac_reg <= '0;
        end else if ((dt_state_reg == DT_RISE) && sense_reg.dtn_ge_3v0) begin
            tick_reg <= '0;
            frac_reg <= '0;
        end else begin
            // Saturate instead of wrapping so an open node reads as maximum.
            if (tick_sum > tick_reg) tick_reg <= tick_sum;
            else tick_reg <= '1;
            frac_reg <= 6'(frac_sum - (two_ticks ? 7'({TICK_STEP, 1'b0})
                                                 : 7'({1'b0, TICK_STEP})));
        end
    end

    // Intervals are captured once; nothing but reset rewrites them.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rise_interval_reg <= '0;
            fall_interval_reg <= '0;
            dt_valid_reg <= 1'b0;
        end else begin
            if ((dt_state_reg == DT_RISE) && sense_reg.dtn_ge_3v0) begin
                rise_interval_reg <= tick_reg;
            end
            if ((dt_state_reg == DT_FALL) && !sense_reg.dtn_ge_1v0) begin
                fall_interval_reg <= tick_reg;
                dt_valid_reg <= 1'b1;
            end
        end
    end

    function automatic logic [3:0] clamp_steps(input logic [TICK_W-1:0] steps);
        if (steps < TICK_W'(MIN_STEPS)) clamp_steps = MIN_STEPS;
        else if (steps > TICK_W'(MAX_STEPS)) clamp_steps = MAX_STEPS;
        else clamp_steps = steps[3:0];
    endfunction

    logic [3:0] rect_steps;
    logic [3:0] prim_steps;
    assign rect_steps = clamp_steps(rise_interval_reg >> `RECT_DIV_SHIFT);
    assign prim_steps = clamp_steps(fall_interval_reg >> `PRIM_DIV_SHIFT);

    // Pulse-width mode follows the comparator whenever software allows it, in every sequencer state.
    logic pwm_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= sense_reg.comp_below_pwm && ctrl_reg[`CTRL_PWM_ALLOW_BIT];
        end
    end
    assign o_pwm_mode = pwm_reg;
    assign o_comp_clamp = pwm_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rect_deadtime <= '0;
            o_prim_deadtime <= '0;
        end else if (pwm_reg) begin
            o_rect_deadtime <= {rect_steps, 1'b0};
            o_prim_deadtime <= {prim_steps, 1'b0};
        end else begin
            o_rect_deadtime <= {1'b0, rect_steps};
            o_prim_deadtime <= {1'b0, prim_steps};
        end
    end
    // The outputs load from the captured counts one clock after capture, so the valid
    // flag is delayed to match; otherwise a user could latch the pre-programming value.
    logic dt_out_valid_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dt_out_valid_reg <= 1'b0;
        end else begin
            dt_out_valid_reg <= dt_valid_reg;
        end
    end
    assign o_deadtime_valid = dt_out_valid_reg;

    // Soft-start and protection sequence.
    ss_state_e ss_state_reg;
    logic [1:0] restart_cnt_reg;
    logic switching;
    logic olp_trip;
    logic osp_trip;
    assign switching = (ss_state_reg == SS_START) || (ss_state_reg == SS_RUN) ||
                       (ss_state_reg == SS_OVERLOAD);
    assign olp_trip = (ss_state_reg == SS_OVERLOAD) && sense_reg.ss_ge_3v6;
    // A short wins over the overload delay and needs no timer.
    assign osp_trip = switching && sense_reg.fb_short;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ss_state_reg <= SS_IDLE;
            restart_cnt_reg <= '0;
        end else if (osp_trip || olp_trip) begin
            ss_state_reg <= SS_RST_CHARGE;
            restart_cnt_reg <= '0;
        end else begin
            unique case (ss_state_reg)
                SS_IDLE: begin
                    if (run_en && dt_valid_reg) ss_state_reg <= SS_START;
                end
                SS_START: begin
                    if (sense_reg.ss_ge_2v4) ss_state_reg <= SS_RUN;
                end
                SS_RUN: begin
                    if (sense_reg.comp_sat_high) ss_state_reg <= SS_OVERLOAD;
                end
                SS_OVERLOAD: begin
                    // Load eased before the trip: the clamp takes the node back.
                    if (!sense_reg.comp_sat_high) ss_state_reg <= SS_RUN;
                end
                SS_RST_CHARGE: begin
                    if (sense_reg.ss_ge_4v7) ss_state_reg <= SS_RST_DISCHARGE;
                end
                SS_RST_DISCHARGE: begin
                    if (sense_reg.ss_le_0v1) begin
                        if (restart_cnt_reg == RESTART_EXTRA) begin
                            ss_state_reg <= SS_START;
                            restart_cnt_reg <= '0;
                        end else begin
                            ss_state_reg <= SS_RST_CHARGE;
                            restart_cnt_reg <= restart_cnt_reg + 2'd1;
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        o_ss_drive = '0;
        o_ss_drive.startup_source = (ss_state_reg == SS_START);
        o_ss_drive.clamp = (ss_state_reg == SS_RUN);
        o_ss_drive.charge_up_source = (ss_state_reg == SS_OVERLOAD) ||
                                      (ss_state_reg == SS_RST_CHARGE);
        o_ss_drive.discharge_source = (ss_state_reg == SS_RST_DISCHARGE);
    end
    assign o_switch_en = switching && !osp_trip && !olp_trip;
    assign o_overload_shutdown = olp_trip;
    assign o_output_short_trip = osp_trip;

    // Avalon-MM slave: one wait state on every access.
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack_reg;
    assign wr_take = i_avs_write && bus_ack_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_ack_reg <= 1'b0;
        end else begin
            bus_ack_reg <= (i_avs_read || i_avs_write) && !bus_ack_reg;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_avs_address)
            `REG_CTRL: rd_mux = ctrl_reg;
            `REG_STATE: rd_mux = {26'h0, restart_cnt_reg, 1'b0, ss_state_reg};
            `REG_DEADTIME: rd_mux = {15'h0, dt_out_valid_reg, 3'h0, o_prim_deadtime,
                                     3'h0, o_rect_deadtime};
            `REG_IRQ_STATUS: rd_mux = {28'h0, irq_status_reg};
            `REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && !bus_ack_reg) begin
            o_avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_take && (i_avs_address == `REG_CTRL) && i_avs_byteenable[0]) begin
            ctrl_reg <= {30'h0, i_avs_writedata[1:0]};
        end
    end

    logic dt_done_seen;
    assign dt_done_seen = (dt_state_reg == DT_FALL) && !sense_reg.dtn_ge_1v0;
    assign events = {dt_done_seen,
                     (ss_state_reg == SS_RST_DISCHARGE) && sense_reg.ss_le_0v1 &&
                     (restart_cnt_reg == RESTART_EXTRA) && !osp_trip,
                     osp_trip, olp_trip};
    // Set beats a write-one clear that lands in the same cycle.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status_reg <= '0;
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else begin
            if (wr_take && (i_avs_address == `REG_IRQ_STATUS) && i_avs_byteenable[0]) begin
                irq_status_reg <= (irq_status_reg & ~i_avs_writedata[`EV_WIDTH-1:0]) | events;
            end else begin
                irq_status_reg <= irq_status_reg | events;
            end
            if (wr_take && (i_avs_address == `REG_IRQ_MASK) && i_avs_byteenable[0]) begin
                irq_mask_reg <= i_avs_writedata[`EV_WIDTH-1:0];
            end
        end
    end
    assign o_irq = |(irq_status_reg & irq_mask_reg);

    // Checks on the sequencing.
    clamp_in_run_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_ss_drive.clamp |-> (ss_state_reg == SS_RUN) && !o_ss_drive.charge_up_source)
        else $error("clamp active outside run");
    startup_src_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (ss_state_reg == SS_START) && !sense_reg.ss_ge_2v4 && !sense_reg.fb_short
        |=> o_ss_drive.startup_source)
        else $error("startup source dropped before 2.4 V");
    overload_release_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (ss_state_reg == SS_RUN) && sense_reg.comp_sat_high && !sense_reg.fb_short
        |=> !o_ss_drive.clamp && o_ss_drive.charge_up_source)
        else $error("overload did not release clamp");
    olp_trip_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_overload_shutdown |=> (ss_state_reg == SS_RST_CHARGE) && !o_switch_en)
        else $error("overload trip did not start restart");
    short_trip_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        switching && sense_reg.fb_short |-> o_output_short_trip && !o_switch_en
        ##1 (ss_state_reg == SS_RST_CHARGE))
        else $error("short not tripped at once");
    restart_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (ss_state_reg == SS_RST_CHARGE) && sense_reg.ss_ge_4v7
        |=> o_ss_drive.discharge_source && !o_ss_drive.clamp)
        else $error("restart charge did not turn to discharge");
    restart_count_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(ss_state_reg == SS_START) && $past(ss_state_reg) == SS_RST_DISCHARGE
        |-> $past(restart_cnt_reg) == RESTART_EXTRA)
        else $error("recovery before four restart cycles");
    dt_src_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (dt_state_reg == DT_DONE) |-> !o_deadtime_discharge_source)
        else $error("discharge source on after programming");
    dt_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        dt_valid_reg ##1 dt_valid_reg |-> $stable(rise_interval_reg) && $stable(fall_interval_reg))
        else $error("dead-time counts changed after capture");
    dt_range_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        dt_valid_reg |-> rect_steps >= MIN_STEPS && rect_steps <= MAX_STEPS &&
                         prim_steps >= MIN_STEPS && prim_steps <= MAX_STEPS)
        else $error("dead time outside limits");
    pwm_double_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        pwm_reg && $stable(pwm_reg) && dt_valid_reg ##1 pwm_reg
        |-> o_prim_deadtime == {prim_steps, 1'b0})
        else $error("dead time not doubled in pulse-width mode");
    tick_rate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (dt_state_reg == DT_RISE) && !sense_reg.dtn_ge_3v0 && (tick_reg < TICK_W'(100))
        |=> (tick_reg - $past(tick_reg)) inside {TICK_W'(1), TICK_W'(2)})
        else $error("tick count off rate");

    dt_done_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(dt_valid_reg));
    olp_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_overload_shutdown);
    osp_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_output_short_trip);
    recover_c: cover property (@(posedge i_clk) disable iff (!i_nrst)
        events[`EV_RECOVER]);
endmodule // llc_softstart_protect_deadtime

// ### inc/llc_ss_regs.svh
// Register offsets, field positions, reset values and timing counts of the sequencer.
`ifndef LLC_SS_REGS_SVH
`define LLC_SS_REGS_SVH
// Word indices on the Avalon-MM slave; byte address is four times the index.
`define REG_CTRL 3'h0
`define REG_STATE 3'h1
`define REG_DEADTIME 3'h2
`define REG_IRQ_STATUS 3'h3
`define REG_IRQ_MASK 3'h4
// Control bits.
`define CTRL_RUN_BIT 0
`define CTRL_PWM_ALLOW_BIT 1
`define CTRL_RESET 32'h0000_0003
// Event bits, shared by the status and mask registers.
`define EV_OVERLOAD 0
`define EV_SHORT 1
`define EV_RECOVER 2
`define EV_DT_DONE 3
`define EV_WIDTH 4
`define IRQ_MASK_RESET 4'h0
// Timing: clock period, measurement tick and dead-time limits in ns, then the limits in steps and the divider shifts.
`define CLK_PERIOD_NS 40
`define DT_TICK_NS 25
`define DT_MIN_NS 75
`define DT_MAX_NS 375
`define DT_MIN_STEPS (`DT_MIN_NS / `DT_TICK_NS)
`define DT_MAX_STEPS (`DT_MAX_NS / `DT_TICK_NS)
`define RECT_DIV_SHIFT 6
`define PRIM_DIV_SHIFT 5
// Restart cycles: the first one plus three more.
`define RESTART_EXTRA 3
`endif

// ### inc/llc_ss_pkg.sv
// Types shared by the soft-start, protection and dead-time sequencer.
package llc_ss_pkg;
    // Digital images of the analog comparators.
    typedef struct packed {
        logic bias_5v_ok;
        logic comp_sat_high;
        logic comp_below_pwm;
        logic fb_short;
        logic ss_ge_2v4;
        logic ss_ge_3v6;
        logic ss_ge_4v7;
        logic ss_le_0v1;
        logic dtn_ge_1v0;
        logic dtn_ge_1v4;
        logic dtn_ge_3v0;
    } sense_s;
    // Soft-start node drive controls.
    typedef struct packed {
        logic startup_source;
        logic charge_up_source;
        logic discharge_source;
        logic clamp;
    } ss_drive_s;
    typedef enum logic [2:0] {
        SS_IDLE, SS_START, SS_RUN, SS_OVERLOAD, SS_RST_CHARGE, SS_RST_DISCHARGE
    } ss_state_e;
    typedef enum logic [2:0] {
        DT_WAIT_BIAS, DT_PRE_RISE, DT_PRE_FALL, DT_RISE, DT_FALL, DT_DONE
    } dt_state_e;
endpackage

// ### testbench/stage_model.sv
// Behavioural power stage: soft-start and dead-time timing nodes seen by the comparators.
`timescale 1ns/1ps
module stage_model
    import llc_ss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire llc_ss_pkg::ss_drive_s i_drive,
    input wire logic i_dt_dis,
    input wire logic [3:0] i_env,
    input wire logic [31:0] i_rise,
    input wire logic [31:0] i_fall,
    output llc_ss_pkg::sense_s o_sense,
    output int o_dt_uv
);
    int ss_mv;
    int ss_next;
    always_comb begin
        ss_next = ss_mv + (i_drive.startup_source ? 10 : 0) + (i_drive.charge_up_source ? 5 : 0);
        ss_next = ss_next - (i_drive.discharge_source ? 20 : 0);
        // The clamp only limits the node from above, as a real clamp diode would.
        if (i_drive.clamp && ss_next > 2400) ss_next = 2400;
        if (ss_next < 0) ss_next = 0;
        if (ss_next > 5000) ss_next = 5000;
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ss_mv <= 0;
            o_dt_uv <= 0;
        end else begin
            ss_mv <= ss_next;
            if (!i_env[3]) o_dt_uv <= 0;
            else if (i_dt_dis) o_dt_uv <= (o_dt_uv > i_fall) ? o_dt_uv - i_fall : 0;
            else o_dt_uv <= (o_dt_uv + i_rise > 5000000) ? 5000000 : o_dt_uv + i_rise;
        end
    end
    assign o_sense = sense_s'({i_env, ss_mv >= 2400, ss_mv >= 3600, ss_mv >= 4700,
        ss_mv <= 100, o_dt_uv >= 1000000, o_dt_uv >= 1400000, o_dt_uv >= 3000000});
endmodule // stage_model

// ### testbench/testbench.sv
// Self-checking bench for the soft-start, protection and dead-time sequencer.
`timescale 1ns/1ps
module testbench;
    import llc_ss_pkg::*;
    logic i_clk = 0;
    logic i_nrst = 0;
    logic [3:0] env = 0;
    logic [31:0] rise = 0;
    logic [31:0] fall = 0;
    logic [2:0] addr = 0;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wdata = 0;
    logic [31:0] q;
    logic [31:0] rdata;
    sense_s sense;
    ss_drive_s drive;
    logic dt_dis, sw_en, pwm, cclamp, overload_shutdown, output_short_trip, dvalid, wait_r, irq;
    logic [4:0] rect;
    logic [4:0] prim;
    int dt_uv;
    int n_errors = 0;
    int num_checks = 0;
    always #20 i_clk = ~i_clk;
    llc_softstart_protect_deadtime dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_sense(sense),
        .o_ss_drive(drive), .o_deadtime_discharge_source(dt_dis), .o_switch_en(sw_en),
        .o_pwm_mode(pwm), .o_comp_clamp(cclamp), .o_overload_shutdown(overload_shutdown),
        .o_output_short_trip(output_short_trip), .o_rect_deadtime(rect), .o_prim_deadtime(prim),
        .o_deadtime_valid(dvalid), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_r), .o_irq(irq));
    stage_model m_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_drive(drive), .i_dt_dis(dt_dis),
        .i_env(env), .i_rise(rise), .i_fall(fall), .o_sense(sense), .o_dt_uv(dt_uv));
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fail(input string m);
        n_errors++;
        $display("MISMATCH %0t timeout %s", $time, m);
        results;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // The request holds until a rising edge samples waitrequest low; the closing negedge
    // lets the caller look at outputs that the accepting edge has settled.
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (wait_r !== 1'b0 && k < 50);
        if (wait_r !== 1'b0) fail("bus");
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge i_clk);
    endtask
    task automatic wait_state(input logic [2:0] s, input int lim);
        for (int k = 0; k < lim; k++) begin
            bus(1'b0, 3'h1, 32'h0);
            if (q[2:0] === s) return;
        end
        fail("state");
    endtask
    task automatic prog(input logic [31:0] r, input logic [31:0] f, input logic [4:0] er,
            input logic [4:0] ep);
        int k;
        @(posedge i_clk);
        rise <= r;
        fall <= f;
        env[3] <= 1'b1;
        for (k = 0; k < 2000 && dt_dis !== 1'b1; k++) @(negedge i_clk);
        chk(dt_uv >= 1400000, 1, "early discharge");
        for (k = 0; k < 9000 && dvalid !== 1'b1; k++) @(negedge i_clk);
        if (dvalid !== 1'b1) fail("valid");
        chk(rect, er, "rect dt");
        chk(prim, ep, "prim dt");
        chk(dt_dis, 0, "source on");
        bus(1'b0, 3'h2, 32'h0);
        chk(q, {15'h0, 1'b1, 3'h0, ep, 3'h0, er}, "dt reg");
    endtask
    // Counts full restart cycles, each discharge counted only once the node reached 4.7 V.
    task automatic restart(input string m);
        int n;
        logic prev;
        n = 0;
        prev = 1'b0;
        for (int k = 0; k < 30000 && drive.startup_source !== 1'b1; k++) begin
            @(negedge i_clk);
            if (drive.discharge_source === 1'b1 && !prev && m_u.ss_mv >= 4700) n++;
            prev = drive.discharge_source;
        end
        chk(n, 4, m);
        chk(m_u.ss_mv <= 100 && drive.clamp === 1'b0, 1, "ramp again");
    endtask
    task automatic soft_start;
        wait_state(3'h1, 50);
        chk(drive.startup_source && sw_en, 1, "start");
        wait_state(3'h2, 200);
        repeat (20) @(negedge i_clk);
        chk(drive.clamp, 1, "clamp");
        chk(m_u.ss_mv, 2400, "ref level");
    endtask
    task automatic overload;
        int k;
        @(posedge i_clk);
        env[2] <= 1'b1;
        wait_state(3'h3, 20);
        chk({drive.clamp, drive.charge_up_source}, 2'b01, "release");
        for (k = 0; k < 1000 && overload_shutdown !== 1'b1; k++) @(negedge i_clk);
        chk(m_u.ss_mv >= 3600 && m_u.ss_mv < 3650, 1, "trip level");
        @(posedge i_clk);
        env[2] <= 1'b0;
        restart("olp cycles");
        bus(1'b0, 3'h3, 32'h0);
        chk(q[3:0], 4'h5, "status");
        chk(irq, 0, "masked irq");
        bus(1'b1, 3'h4, 32'h1);
        chk(irq, 1, "irq");
        bus(1'b1, 3'h3, 32'h1);
        chk(irq, 0, "irq clear");
        bus(1'b0, 3'h5, 32'h0);
        chk(q, 0, "unmapped");
    endtask
    task automatic short_trip;
        int k;
        wait_state(3'h2, 200);
        @(posedge i_clk);
        env[0] <= 1'b1;
        for (k = 0; k < 4 && output_short_trip !== 1'b1; k++) @(negedge i_clk);
        chk(output_short_trip, 1, "short trip");
        @(posedge i_clk);
        env[0] <= 1'b0;
        restart("osp cycles");
        bus(1'b0, 3'h3, 32'h0);
        chk(q[1], 1, "short status");
    endtask
    task automatic pwm_mode;
        wait_state(3'h2, 200);
        @(posedge i_clk);
        env[1] <= 1'b1;
        repeat (5) @(negedge i_clk);
        chk({pwm, cclamp}, 2'b11, "pwm entry");
        chk({rect, prim}, {5'h14, 5'h16}, "doubled");
        bus(1'b1, 3'h0, 32'h1);
        repeat (5) @(negedge i_clk);
        chk({pwm, rect, prim}, {1'b0, 5'h0a, 5'h0b}, "pwm off");
        bus(1'b1, 3'h0, 32'h3);
        @(posedge i_clk);
        env[1] <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        prog(32'd4762, 32'd9091, 5'h0a, 5'h0b);
        bus(1'b1, 3'h3, 32'h8);
        bus(1'b0, 3'h3, 32'h0);
        chk(q, 0, "w1c");
        soft_start;
        overload;
        short_trip;
        pwm_mode;
        @(posedge i_clk);
        i_nrst <= 1'b0;
        env <= 4'h0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        // Too-fast rectifier and too-slow primary part choice, used to reach the lower and upper clamps.
        prog(32'd50000, 32'd1000, 5'h03, 5'h0f);
        results;
    end
endmodule // testbench
